// file: pkg/ct_supervision_pkg.sv
/*
 * Constants of the transformer supervision element: register map,
 * reset values, limits, timing counts and timer states.
 * Assumes a 20 MHz core clock and RATED_CODE counts per rated current.
 */
package ct_supervision_pkg;
    localparam int          ADDR_W         = 6;
    // Register byte offsets.
    localparam logic [5:0]  CTRL_OFS       = 6'h00;
    localparam logic [5:0]  PICKUP_OFS     = 6'h04;
    localparam logic [5:0]  DELAY_OFS      = 6'h08;
    localparam logic [5:0]  KD_OFS         = 6'h0c;
    localparam logic [5:0]  CT_PHASE_OFS   = 6'h10;
    localparam logic [5:0]  CT_EARTH_OFS   = 6'h14;
    localparam logic [5:0]  STATUS_OFS     = 6'h18;
    localparam logic [5:0]  IRQ_STAT_OFS   = 6'h1c;
    localparam logic [5:0]  IRQ_MASK_OFS   = 6'h20;
    // Control field positions.
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_PERMIT_BIT = 1;
    localparam int          CTRL_ASG1_BIT  = 2;
    localparam int          CTRL_ASG2_BIT  = 3;
    // Status and interrupt field positions.
    localparam int          ST_ACTIVE_BIT  = 0;
    localparam int          ST_BLOCKED_BIT = 1;
    localparam int          ST_ALARM_BIT   = 2;
    localparam int          ST_IN1_BIT     = 3;
    localparam int          ST_IN2_BIT     = 4;
    localparam int          EV_ALARM_BIT   = 0;
    localparam int          EV_BLOCKED_BIT = 1;
    // Reset values and limits; pickup and factor in hundredths.
    localparam logic [3:0]  CTRL_RESET     = 4'h0;
    localparam logic [6:0]  PICKUP_RESET   = 7'h32;
    localparam logic [31:0] PICKUP_MIN     = 32'h0000_000a;
    localparam logic [31:0] PICKUP_MAX     = 32'h0000_0064;
    localparam logic [16:0] DELAY_RESET    = 17'h0_000a;
    localparam logic [31:0] DELAY_MIN      = 32'h0000_0001;
    localparam logic [31:0] DELAY_MAX      = 32'h0001_8696;
    localparam logic [6:0]  KD_RESET       = 7'h00;
    localparam logic [31:0] KD_MAX         = 32'h0000_0063;
    localparam logic [31:0] CT_RESET       = 32'h0001_0001;
    localparam logic [1:0]  IRQ_RESET      = 2'h0;
    localparam logic [55:0] PCT_SCALE      = 56'h00_0000_0000_0064;
    localparam int          KI_FRAC        = 8;
    localparam logic [15:0] KI_ONE         = 16'h0100;
    localparam logic [15:0] RATED_CODE     = 16'h03e8;
    // Timing: the delay is counted in steps of 0.1 s.
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          DELAY_STEP_NS  = 100_000_000;
    localparam int          TICK_CYCLES    = DELAY_STEP_NS / CLK_PERIOD_NS;
    // Bus responses.
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_TIMING = 2'b01,
        ST_ALARM  = 2'b11
    } sup_state_e;
endpackage : ct_supervision_pkg

// file: rtl/ct_supervision_alarm.sv
/*
 * Current transformer supervision element with an AXI4-Lite register file.
 * Compares measured earth current, scaled by the ratio factor, with the
 * residual current of the three phases and raises a delayed alarm.
 * Assumes phasor samples (real, imaginary) on the core clock and
 * asynchronous external blocking pins.
 */
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
// Summary of operation
// RULE1: Enable is off after reset; while off, no evaluation and no alarm.
// RULE2: The block permit matters only when a blocking input is assigned.
// RULE3: An assigned input going true with permit set blocks and flags it.
// RULE4: Alarm after delay over threshold, 0.1 s to 9999.0 s, default 1.0 s.
// RULE5: Pickup is 0.10 to 1.00 times rated current, default 0.50.
// RULE6: Dynamic factor 0.00 to 0.99, default 0.00, scales compensation.
// RULE7: Active, externally blocked and alarm status outputs are provided.
// RULE8: The live states of both blocking inputs are readable.
// RULE9: Pickup 0.1 and one phase lost from nominal current gives alarm.
// RULE10: Earth current over threshold, phases symmetric, raises alarm.
// RULE11: Threshold is pickup plus dynamic factor times largest phase.
// RULE12: Earth current is scaled by a ratio from the rated CT values.
// RULE13: Timer and alarm clear on fall back, when off or when blocked.
// RULE14: The active output is high only while enabled and not blocked.
`timescale 1ns/10ps
module ct_supervision_alarm #(
    parameter int          TICK_CYCLES = ct_supervision_pkg::TICK_CYCLES,
    parameter logic [15:0] RATED_CODE  = ct_supervision_pkg::RATED_CODE
) (
    // Clock and reset.
    input  wire logic                                   core_clk,
    input  wire logic                                   resetn,
    // AXI4-Lite slave.
    input  wire logic [ct_supervision_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                                   s_axi_awvalid,
    output wire logic                                   s_axi_awready,
    input  wire logic [31:0]                            s_axi_wdata,
    input  wire logic [3:0]                             s_axi_wstrb,
    input  wire logic                                   s_axi_wvalid,
    output wire logic                                   s_axi_wready,
    output logic      [1:0]                             s_axi_bresp,
    output logic                                        s_axi_bvalid,
    input  wire logic                                   s_axi_bready,
    input  wire logic [ct_supervision_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                                   s_axi_arvalid,
    output wire logic                                   s_axi_arready,
    output logic      [31:0]                            s_axi_rdata,
    output logic      [1:0]                             s_axi_rresp,
    output logic                                        s_axi_rvalid,
    input  wire logic                                   s_axi_rready,
    // Phase and earth current phasors.
    input  wire logic signed [15:0]                     cur_l1_re,
    input  wire logic signed [15:0]                     cur_l1_im,
    input  wire logic signed [15:0]                     cur_l2_re,
    input  wire logic signed [15:0]                     cur_l2_im,
    input  wire logic signed [15:0]                     cur_l3_re,
    input  wire logic signed [15:0]                     cur_l3_im,
    input  wire logic signed [15:0]                     cur_earth_re,
    input  wire logic signed [15:0]                     cur_earth_im,
    // External blocking pins.
    input  wire logic                                   ext_block_in_one,
    input  wire logic                                   ext_block_in_two,
    // Status outputs.
    output logic                                        elem_active,
    output logic                                        ext_blocked_flag,
    output logic                                        ct_alarm,
    output wire logic                                   irq
);
    import ct_supervision_pkg::*;

    // Magnitude estimate: larger part plus 3/8 of the smaller.
    function automatic logic [39:0] mag_approx(
        input logic signed [39:0] re,
        input logic signed [39:0] im
    );
        logic [39:0] a;
        logic [39:0] b;
        a = re[39] ? 40'(-re) : 40'(re);
        b = im[39] ? 40'(-im) : 40'(im);
        return (a < b) ? b + (a >> 2) + (a >> 3) : a + (b >> 2) + (b >> 3);
    endfunction : mag_approx

    function automatic logic [31:0] clamp(
        input logic [31:0] v,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    logic [3:0]  ctrl;
    logic [6:0]  pickup;
    logic [16:0] delay_set;
    logic [6:0]  dynamic_ratio_factor;
    logic [31:0] ct_phase;
    logic [31:0] ct_earth;
    logic [15:0] earth_ratio_factor;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [1:0]  blk_meta;
    logic [1:0]  blk_sync;
    logic [39:0] diff_mag;
    logic [39:0] phase_max;
    logic        over;
    logic [31:0] prescale;
    logic [16:0] tenths;
    sup_state_e  state;
    sup_state_e  next_state;
    logic        alarm_prev;
    logic        blocked_prev;
    logic                aw_held;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;

    // Write channel: address and data are taken in either order.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire        wr_go   = aw_held && w_held;
    wire        rd_go   = s_axi_arvalid && s_axi_arready;
    wire [31:0] wmask;
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask[8*i +: 8] = {8{w_strb[i]}};
    end

    wire wr_ctrl   = wr_go && (aw_addr == CTRL_OFS);
    wire wr_pickup = wr_go && (aw_addr == PICKUP_OFS);
    wire wr_delay  = wr_go && (aw_addr == DELAY_OFS);
    wire wr_kd     = wr_go && (aw_addr == KD_OFS);
    wire wr_ctph   = wr_go && (aw_addr == CT_PHASE_OFS);
    wire wr_cter   = wr_go && (aw_addr == CT_EARTH_OFS);
    wire wr_istat  = wr_go && (aw_addr == IRQ_STAT_OFS);
    wire wr_imask  = wr_go && (aw_addr == IRQ_MASK_OFS);
    wire wr_stat   = wr_go && (aw_addr == STATUS_OFS);
    wire wr_hit    = wr_ctrl || wr_pickup || wr_delay || wr_kd || wr_ctph
                     || wr_cter || wr_istat || wr_imask || wr_stat;

    wire [31:0] m_ctrl   = ({28'h000_0000, ctrl} & ~wmask) | (w_data & wmask);
    wire [31:0] m_pickup = (32'(pickup) & ~wmask) | (w_data & wmask);
    wire [31:0] m_delay  = (32'(delay_set) & ~wmask) | (w_data & wmask);
    wire [31:0] m_kd     = ({25'h000_0000, dynamic_ratio_factor} & ~wmask)
                           | (w_data & wmask);
    wire [31:0] m_ctph   = (ct_phase & ~wmask) | (w_data & wmask);
    wire [31:0] m_cter   = (ct_earth & ~wmask) | (w_data & wmask);
    wire [31:0] m_imask  = (32'(irq_mask) & ~wmask) | (w_data & wmask);
    wire [1:0]  w1c      = wr_istat ? (w_data[1:0] & wmask[1:0]) : 2'h0;

    // Settings are limited to their documented ranges on write.
    wire [6:0]  next_pickup = wr_pickup ?
        7'(clamp(m_pickup, PICKUP_MIN, PICKUP_MAX)) : pickup;   // RULE5
    wire [16:0] next_delay  = wr_delay ?
        17'(clamp(m_delay, DELAY_MIN, DELAY_MAX)) : delay_set;  // RULE4
    wire [6:0]  next_kd     = wr_kd ?
        7'(clamp(m_kd, 32'h0000_0000, KD_MAX)) : dynamic_ratio_factor; // RULE6

    // Ratio factor in Q8: (earth primary/secondary)/(phase primary/second.).
    wire [31:0] ki_num = ct_earth[15:0] * ct_phase[31:16];
    wire [31:0] ki_den = ct_earth[31:16] * ct_phase[15:0];
    wire [39:0] ki_quo = (ki_den == 32'h0000_0000) ? 40'(KI_ONE)
                         : ({ki_num, 8'h00} / 40'(ki_den));
    wire [15:0] next_ki = (ki_quo > 40'h00_0000_ffff) ? 16'hffff
                          : ki_quo[15:0];                       // RULE12

    wire enabled   = ctrl[CTRL_EN_BIT];
    wire [1:0] asg = {ctrl[CTRL_ASG2_BIT], ctrl[CTRL_ASG1_BIT]};
    wire blocked   = enabled && ctrl[CTRL_PERMIT_BIT]
                     && |(asg & blk_sync);                     // RULE2 RULE3
    wire run       = enabled && !blocked;                       // RULE1 RULE14

    // Residual difference in Q8: sum of phases plus scaled earth current.
    wire signed [17:0] sum_re = 18'(cur_l1_re) + 18'(cur_l2_re)
                                + 18'(cur_l3_re);
    wire signed [17:0] sum_im = 18'(cur_l1_im) + 18'(cur_l2_im)
                                + 18'(cur_l3_im);
    wire signed [16:0] ki_s   = $signed({1'b0, earth_ratio_factor});
    wire signed [39:0] dif_re = (40'(sum_re) <<< KI_FRAC)
                                + 40'(ki_s * cur_earth_re);     // RULE12
    wire signed [39:0] dif_im = (40'(sum_im) <<< KI_FRAC)
                                + 40'(ki_s * cur_earth_im);
    wire [39:0] mag_l1 = mag_approx(40'(cur_l1_re), 40'(cur_l1_im));
    wire [39:0] mag_l2 = mag_approx(40'(cur_l2_re), 40'(cur_l2_im));
    wire [39:0] mag_l3 = mag_approx(40'(cur_l3_re), 40'(cur_l3_im));
    wire [39:0] max_12 = (mag_l1 > mag_l2) ? mag_l1 : mag_l2;
    wire [39:0] next_max = (max_12 > mag_l3) ? max_12 : mag_l3;

    // Compare 100*|diff| against 256*(pickup*In + factor*Imax).
    wire [55:0] lhs = 56'(diff_mag) * PCT_SCALE;
    wire [55:0] rhs = (56'(pickup) * 56'(RATED_CODE)
                      + 56'(dynamic_ratio_factor) * 56'(phase_max))
                      << KI_FRAC;                               // RULE11
    wire next_over  = lhs > rhs;                  // RULE9 RULE10

    wire step_end  = (prescale == 32'(TICK_CYCLES - 1));
    wire delay_hit = step_end && ((tenths + 17'h0_0001) >= delay_set);
    wire go        = run && over;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:   if (go) next_state = ST_TIMING;
            ST_TIMING: begin
                if (!go) begin
                    next_state = ST_IDLE;                       // RULE13
                end else if (delay_hit) begin
                    next_state = ST_ALARM;                      // RULE4
                end
            end
            ST_ALARM:  if (!go) next_state = ST_IDLE;           // RULE13
            default:   next_state = ST_IDLE;
        endcase
    end

    wire alarm_now = (next_state == ST_ALARM);
    wire [1:0] events = {blocked && !blocked_prev, alarm_now && !alarm_prev};
    // A new event wins over a simultaneous clear.
    wire [1:0] next_istat = (irq_stat & ~w1c) | events;
    assign irq = |(irq_stat & irq_mask);

    wire [4:0] status = {blk_sync, ct_alarm, ext_blocked_flag, elem_active};

    logic [31:0] rd_val;
    logic [1:0]  rd_resp;
    always_comb begin
        rd_val  = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        case (s_axi_araddr)
            CTRL_OFS:     rd_val = {28'h000_0000, ctrl};
            PICKUP_OFS:   rd_val = {25'h000_0000, pickup};
            DELAY_OFS:    rd_val = {15'h0000, delay_set};
            KD_OFS:       rd_val = {25'h000_0000, dynamic_ratio_factor};
            CT_PHASE_OFS: rd_val = ct_phase;
            CT_EARTH_OFS: rd_val = ct_earth;
            STATUS_OFS:   rd_val = {27'h000_0000, status};      // RULE8
            IRQ_STAT_OFS: rd_val = {30'h0000_0000, irq_stat};
            IRQ_MASK_OFS: rd_val = {30'h0000_0000, irq_mask};
            default:      rd_resp = RESP_DECERR;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= '0;
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_resp;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl                 <= CTRL_RESET;                 // RULE1
            pickup               <= PICKUP_RESET;
            delay_set            <= DELAY_RESET;
            dynamic_ratio_factor <= KD_RESET;
            ct_phase             <= CT_RESET;
            ct_earth             <= CT_RESET;
            earth_ratio_factor   <= KI_ONE;
            irq_mask             <= IRQ_RESET;
            irq_stat             <= IRQ_RESET;
        end else begin
            ctrl                 <= wr_ctrl ? m_ctrl[3:0] : ctrl;
            pickup               <= next_pickup;
            delay_set            <= next_delay;
            dynamic_ratio_factor <= next_kd;
            ct_phase             <= wr_ctph ? m_ctph : ct_phase;
            ct_earth             <= wr_cter ? m_cter : ct_earth;
            earth_ratio_factor   <= next_ki;
            irq_mask             <= wr_imask ? m_imask[1:0] : irq_mask;
            irq_stat             <= next_istat;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            blk_meta         <= 2'h0;
            blk_sync         <= 2'h0;
            diff_mag         <= 40'h00_0000_0000;
            phase_max        <= 40'h00_0000_0000;
            over             <= 1'b0;
            state            <= ST_IDLE;
            prescale         <= 32'h0000_0000;
            tenths           <= 17'h0_0000;
            elem_active      <= 1'b0;
            ext_blocked_flag <= 1'b0;
            ct_alarm         <= 1'b0;
            alarm_prev       <= 1'b0;
            blocked_prev     <= 1'b0;
        end else begin
            blk_meta         <= {ext_block_in_two, ext_block_in_one};
            blk_sync         <= blk_meta;
            diff_mag         <= mag_approx(dif_re, dif_im);
            phase_max        <= next_max;
            over             <= next_over;
            state            <= next_state;
            prescale         <= (state != ST_TIMING || step_end)
                                ? 32'h0000_0000 : prescale + 32'h0000_0001;
            tenths           <= (state != ST_TIMING) ? 17'h0_0000
                                : tenths + 17'(step_end);
            elem_active      <= run;                            // RULE7 RULE14
            ext_blocked_flag <= blocked;                        // RULE3 RULE7
            ct_alarm         <= alarm_now;                      // RULE7 RULE13
            alarm_prev       <= alarm_now;
            blocked_prev     <= blocked;
        end
    end
endmodule : ct_supervision_alarm

// file: testbench/ct_current_source.sv
/*
 * Stand-in for the current measuring inputs: a nominal symmetric
 * three-phase system with phase one removable and an in-phase earth.
 * Assumes RATED_CODE counts equal rated current.
 */
`timescale 1ns/10ps
module ct_current_source #(
    parameter logic signed [15:0] NOM  = 16'sh03e8,
    parameter logic signed [15:0] HALF = 16'sh01f4,
    parameter logic signed [15:0] QUAD = 16'sh0362
) (
    // Scenario controls.
    input  wire logic               drop_l1,
    input  wire logic signed [15:0] earth_amp,
    // Phasor outputs.
    output wire logic signed [15:0] l1_re,
    output wire logic signed [15:0] l1_im,
    output wire logic signed [15:0] l2_re,
    output wire logic signed [15:0] l2_im,
    output wire logic signed [15:0] l3_re,
    output wire logic signed [15:0] l3_im,
    output wire logic signed [15:0] e_re,
    output wire logic signed [15:0] e_im
);
    // A removed phase reads as zero while the others stay balanced.
    assign l1_re = drop_l1 ? 16'sh0000 : NOM;
    assign l1_im = 16'sh0000;
    assign l2_re = -HALF;
    assign l2_im = -QUAD;
    assign l3_re = -HALF;
    assign l3_im = QUAD;
    assign e_re  = earth_amp;
    assign e_im  = 16'sh0000;
endmodule : ct_current_source

// file: testbench/ct_supervision_alarm_assertions.sv
/*
 * Port-level checks of the supervision element and its register bus.
 * Assumes it is bound into every instance of the element.
 */
`timescale 1ns/10ps
module ct_supervision_alarm_chk (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Bus handshakes.
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Element pins.
    input wire logic ext_block_in_one,
    input wire logic ext_block_in_two,
    input wire logic elem_active,
    input wire logic ext_blocked_flag,
    input wire logic ct_alarm
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    chk_rd_clear: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read answer not released");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write answer not released");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during answer");
    chk_active_block: assert property (
        !(elem_active && ext_blocked_flag)) else $error("active while blocked");
    chk_alarm_running: assert property (
        $rose(ct_alarm) |-> elem_active) else $error("alarm while not running");
    chk_block_cause: assert property (
        $rose(ext_blocked_flag) |->
        $past(ext_block_in_one || ext_block_in_two, 3))
        else $error("blocked without a blocking pin");
    chk_alarm_drop: assert property (
        $fell(elem_active) |-> ##[0:2] !ct_alarm) else $error("alarm held");
    cover property ($rose(ct_alarm));
    cover property ($fell(ct_alarm));
    cover property ($rose(ext_blocked_flag));
endmodule : ct_supervision_alarm_chk
bind ct_supervision_alarm ct_supervision_alarm_chk chk_u (.*);

// file: testbench/ct_supervision_alarm_tb.sv
/*
 * Self-checking bench: register tasks over AXI4-Lite, a current source
 * model on the measuring inputs, blocking pins driven here.
 * Assumes the tick is shortened to 10 cycles.
 */
`timescale 1ns/10ps
module ct_supervision_alarm_tb;
    import ct_supervision_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, in1 = 1'b0, in2 = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, drop_l1 = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, irq, act, blk, alm;
    logic [1:0] bresp, rresp, rsp;
    logic signed [15:0] earth_amp = 16'sh0000;
    logic signed [15:0] c1r, c1i, c2r, c2i, c3r, c3i, cer, cei;
    logic [5:0] ofs [5] = '{PICKUP_OFS, PICKUP_OFS, DELAY_OFS, DELAY_OFS,
        KD_OFS};
    logic [31:0] wv [5] = '{32'h0000_0005, 32'h0000_00c8, 32'h0000_0000,
        32'h0003_0000, 32'h0000_0096};
    logic [31:0] ev [5] = '{32'h0000_000a, 32'h0000_0064, 32'h0000_0001,
        32'h0001_8696, 32'h0000_0063};
    int err_count = 0, n_tests = 0;
    always #25 core_clk = ~core_clk;
    ct_current_source src_u (.drop_l1(drop_l1), .earth_amp(earth_amp),
        .l1_re(c1r), .l1_im(c1i), .l2_re(c2r), .l2_im(c2i), .l3_re(c3r),
        .l3_im(c3i), .e_re(cer), .e_im(cei));
    ct_supervision_alarm #(.TICK_CYCLES(10)) dut_u (.core_clk(core_clk),
        .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .cur_l1_re(c1r), .cur_l1_im(c1i),
        .cur_l2_re(c2r), .cur_l2_im(c2i), .cur_l3_re(c3r), .cur_l3_im(c3i),
        .cur_earth_re(cer), .cur_earth_im(cei), .ext_block_in_one(in1),
        .ext_block_in_two(in2), .elem_active(act), .ext_blocked_flag(blk),
        .ct_alarm(alm), .irq(irq));
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        rsp = bresp;
        check("bvalid", 1'b1, bvalid);
        if (n >= 40) give_verdict();
    endtask : wr
    task automatic rd_reg(input logic [5:0] a);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        rd = rdata;
        rsp = rresp;
        check("rvalid", 1'b1, rvalid);
        if (n >= 40) give_verdict();
    endtask : rd_reg
    task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
        rd_reg(a);
        check("register", e, rd);
    endtask : chk_rd
    task automatic wait_alarm(input logic e, input int lim);
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (alm !== e && n < lim);
        check("ct_alarm", e, alm);
        if (alm !== e) give_verdict();
    endtask : wait_alarm
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        chk_rd(CTRL_OFS, 32'h0000_0000);
        chk_rd(PICKUP_OFS, 32'h0000_0032);
        chk_rd(DELAY_OFS, 32'h0000_000a);
        chk_rd(KD_OFS, 32'h0000_0000);
        chk_rd(IRQ_MASK_OFS, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], wv[i]);
            chk_rd(ofs[i], ev[i]);
        end
        wr(6'h24, 32'h0000_ffff);
        check("unmapped write", RESP_DECERR, rsp);
        rd_reg(6'h24);
        check("unmapped read", 32'h0000_0003, {rd[29:0], rsp});
        wr(DELAY_OFS, 32'h0000_0002);
        wr(KD_OFS, 32'h0000_0000);
        wr(PICKUP_OFS, 32'h0000_000a);
        drop_l1 <= 1'b1;
        repeat (60) @(posedge core_clk);
        check("disabled", 32'h0000_0000, {act, alm});
        wr(CTRL_OFS, 32'h0000_0001);
        repeat (15) @(posedge core_clk);
        check("early alarm", 1'b0, alm);
        wait_alarm(1'b1, 30);
        repeat (2) @(posedge core_clk);
        check("masked irq", 1'b0, irq);
        chk_rd(IRQ_STAT_OFS, 32'h0000_0001);
        wr(IRQ_MASK_OFS, 32'h0000_0001);
        check("irq", 1'b1, irq);
        wr(IRQ_STAT_OFS, 32'h0000_0001);
        check("cleared irq", 1'b0, irq);
        chk_rd(STATUS_OFS, 32'h0000_0005);
        drop_l1 <= 1'b0;
        wait_alarm(1'b0, 10);
        wr(PICKUP_OFS, 32'h0000_0032);
        earth_amp <= 16'sh0258;
        wait_alarm(1'b1, 40);
        wr(KD_OFS, 32'h0000_0014);
        wait_alarm(1'b0, 10);
        wr(KD_OFS, 32'h0000_0000);
        wait_alarm(1'b1, 40);
        earth_amp <= 16'sh012c;
        wait_alarm(1'b0, 10);
        wr(CT_EARTH_OFS, 32'h0001_0002);
        wait_alarm(1'b1, 40);
        in1 <= 1'b1;
        wr(CTRL_OFS, 32'h0000_0003);
        repeat (8) @(posedge core_clk);
        check("unassigned", 32'h0000_0003, {blk, act, alm});
        chk_rd(STATUS_OFS, 32'h0000_000d);
        wr(CTRL_OFS, 32'h0000_0007);
        repeat (6) @(posedge core_clk);
        check("blocked one", 32'h0000_0004, {blk, act, alm});
        rd_reg(IRQ_STAT_OFS);
        check("blocked event", 1'b1, rd[EV_BLOCKED_BIT]);
        in1 <= 1'b0;
        in2 <= 1'b1;
        wr(CTRL_OFS, 32'h0000_000b);
        repeat (6) @(posedge core_clk);
        chk_rd(STATUS_OFS, 32'h0000_0012);
        wr(CTRL_OFS, 32'h0000_0009);
        repeat (6) @(posedge core_clk);
        check("no permit", 32'h0000_0001, {blk, act});
        give_verdict();
    end
endmodule : ct_supervision_alarm_tb
